//--- rtl/gpio_pkg.sv
// Shared constants and carriers for the eight-pin general-purpose port
package gpio_pkg;

  // Port width, reset values of ordinary pins and lock status codes
  localparam int PINS = 8;
  localparam logic [7:0] ALL_CLEAR = 8'h00;
  localparam logic [7:0] ALL_SET = 8'hFF;
  localparam logic [7:0] DRIVE_LOW_RESET = 8'hFF;
  localparam logic [7:0] LOCK_STATUS_LOCKED = 8'h01;
  localparam logic [7:0] LOCK_STATUS_OPEN = 8'h00;

  // Selector of the configuration access port
  typedef enum logic [5:0] {
    SEL_DIRECTION = 6'h00,
    SEL_SENSE = 6'h01,
    SEL_BOTH_EDGES = 6'h02,
    SEL_EVENT = 6'h03,
    SEL_MASK = 6'h04,
    SEL_RAW_STATUS = 6'h05,
    SEL_MASKED_STATUS = 6'h06,
    SEL_CLEAR = 6'h07,
    SEL_ALT_FUNCTION = 6'h08,
    SEL_DRIVE_LOW = 6'h09,
    SEL_DRIVE_MID = 6'h0A,
    SEL_DRIVE_HIGH = 6'h0B,
    SEL_OPEN_DRAIN = 6'h0C,
    SEL_PULL_UP = 6'h0D,
    SEL_PULL_DOWN = 6'h0E,
    SEL_SLEW = 6'h0F,
    SEL_DIGITAL_EN = 6'h10,
    SEL_LOCK = 6'h11,
    SEL_COMMIT = 6'h12
  } cfg_sel_t;

  // Identification registers: eight peripheral then four cell codes
  localparam logic [5:0] SEL_IDENT_BASE = 6'h20;
  localparam logic [5:0] SEL_IDENT_LAST = 6'h2B;

  // Configuration access request
  typedef struct packed {
    logic we;
    logic re;
    cfg_sel_t sel;
    logic [7:0] wdata;
  } cfg_req_t;

  // Masked data access request; addr_mask carries address bits 9..2
  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr_mask;
    logic [7:0] wdata;
  } data_req_t;

  // Pad controls sent to the pad ring
  typedef struct packed {
    logic [7:0] pull_up_select;
    logic [7:0] pull_down_select;
    logic [7:0] open_drain_select;
    logic [7:0] drive_low_select;
    logic [7:0] drive_mid_select;
    logic [7:0] drive_high_select;
    logic [7:0] slew_control_select;
    logic [7:0] digital_input_enable;
  } pad_cfg_t;

  // All software-held configuration state
  typedef struct packed {
    logic [7:0] pin_direction;
    logic [7:0] irq_sense_select;
    logic [7:0] irq_both_edges;
    logic [7:0] irq_event_polarity;
    logic [7:0] irq_mask;
    logic [7:0] alt_function_select;
    logic [7:0] commit_enable;
    logic unlocked;
    pad_cfg_t pad;
  } cfg_regs_t;

endpackage

//--- rtl/gpio_port_block.sv
`timescale 1ns/1ns
`default_nettype none

module gpio_port_block #(
  parameter logic [7:0] DEBUG_PINS = 8'h0F,
  parameter logic [7:0] CONNECTED = 8'hFF,
  parameter logic [7:0] UNLOCK_KEY = 8'hA5,
  // Identification values are arbitrary
  parameter logic [95:0] IDENT_VALUES = 96'h0C0B0A09_08070605_04030201
) (
  // Clock and resets
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic EXT_RESET_N,
  // Configuration access
  input wire gpio_pkg::cfg_req_t CFG_REQ,
  output logic [7:0] CFG_RDATA,
  // Masked data access
  input wire gpio_pkg::data_req_t DATA_REQ,
  output logic [7:0] DATA_RDATA,
  // Pads
  input wire logic [7:0] PAD_IN,
  output logic [7:0] PAD_OUT,
  output logic [7:0] PAD_OE,
  output gpio_pkg::pad_cfg_t PAD_CFG,
  // Alternate-function peripherals
  input wire logic [7:0] ALT_OUT,
  input wire logic [7:0] ALT_OE,
  output logic [7:0] ALT_IN,
  output logic [7:0] ALT_SELECT,
  // Port interrupt
  output logic IRQ
);

  ////////////////////////////////////////////////////////////////////////////////
  // Defaults, shared by power-on and external reset
  localparam gpio_pkg::cfg_regs_t CFG_DEFAULT = '{
    pin_direction: gpio_pkg::ALL_CLEAR,
    irq_sense_select: gpio_pkg::ALL_CLEAR,
    irq_both_edges: gpio_pkg::ALL_CLEAR,
    irq_event_polarity: gpio_pkg::ALL_CLEAR,
    irq_mask: gpio_pkg::ALL_CLEAR,
    alt_function_select: DEBUG_PINS,
    commit_enable: ~DEBUG_PINS,
    unlocked: 1'b0,
    pad: '{
      pull_up_select: DEBUG_PINS,
      pull_down_select: gpio_pkg::ALL_CLEAR,
      open_drain_select: gpio_pkg::ALL_CLEAR,
      drive_low_select: gpio_pkg::DRIVE_LOW_RESET,
      drive_mid_select: gpio_pkg::ALL_CLEAR,
      drive_high_select: gpio_pkg::ALL_CLEAR,
      slew_control_select: gpio_pkg::ALL_CLEAR,
      digital_input_enable: DEBUG_PINS
    }
  };

  // Register update that leaves bits without a pad untouched
  function automatic logic [7:0] upd(input logic [7:0] cur, input logic wr,
                                     input logic [7:0] val, input logic [7:0] bits);
    upd = wr ? ((cur & ~bits) | (val & bits)) : cur;
  endfunction

  logic ext_meta, ext_sync, ext_rst;
  logic [7:0] pin_meta, pin_sync, pin_prev;
  gpio_pkg::cfg_regs_t cfg, next_cfg;
  logic [7:0] pin_data, next_pin_data, irq_raw_status, next_irq_raw;

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronisers for the external reset pin and the pad inputs
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end else begin
      ext_meta <= EXT_RESET_N;
      ext_sync <= ext_meta;
      pin_meta <= PAD_IN;
      pin_sync <= pin_meta;
    end
  end

  // External reset acts synchronously, so the port state never glitches mid-cycle
  assign ext_rst = ~ext_sync;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration write decode
  logic [7:0] wbits, wr_clear, alt_ok, commit_ok;
  logic wr_dl, wr_dm, wr_dh;
  wire cfg_we = CFG_REQ.we;
  wire gpio_pkg::cfg_sel_t sel = CFG_REQ.sel;
  assign wbits = CFG_REQ.wdata & CONNECTED;
  assign wr_dl = cfg_we && sel == gpio_pkg::SEL_DRIVE_LOW;
  assign wr_dm = cfg_we && sel == gpio_pkg::SEL_DRIVE_MID;
  assign wr_dh = cfg_we && sel == gpio_pkg::SEL_DRIVE_HIGH;
  assign wr_clear = (cfg_we && sel == gpio_pkg::SEL_CLEAR) ? wbits : 8'h00;
  // Debug pins are the only protected ones
  assign alt_ok = CONNECTED & (~DEBUG_PINS | (cfg.commit_enable & {8{cfg.unlocked}}));
  assign commit_ok = CONNECTED & DEBUG_PINS & {8{cfg.unlocked}};

  // Next configuration; drive strengths are mutually exclusive per pin
  always_comb begin
    next_cfg = cfg;
    next_cfg.pin_direction = upd(cfg.pin_direction,
      cfg_we && sel == gpio_pkg::SEL_DIRECTION, wbits, CONNECTED);
    next_cfg.irq_sense_select = upd(cfg.irq_sense_select,
      cfg_we && sel == gpio_pkg::SEL_SENSE, wbits, CONNECTED);
    next_cfg.irq_both_edges = upd(cfg.irq_both_edges,
      cfg_we && sel == gpio_pkg::SEL_BOTH_EDGES, wbits, CONNECTED);
    next_cfg.irq_event_polarity = upd(cfg.irq_event_polarity,
      cfg_we && sel == gpio_pkg::SEL_EVENT, wbits, CONNECTED);
    next_cfg.irq_mask = upd(cfg.irq_mask,
      cfg_we && sel == gpio_pkg::SEL_MASK, wbits, CONNECTED);
    next_cfg.alt_function_select = upd(cfg.alt_function_select,
      cfg_we && sel == gpio_pkg::SEL_ALT_FUNCTION, wbits, alt_ok);
    next_cfg.commit_enable = upd(cfg.commit_enable,
      cfg_we && sel == gpio_pkg::SEL_COMMIT, wbits, commit_ok);
    if (cfg_we && sel == gpio_pkg::SEL_LOCK) begin
      next_cfg.unlocked = CFG_REQ.wdata == UNLOCK_KEY;
    end
    next_cfg.pad.drive_low_select = upd(cfg.pad.drive_low_select, wr_dl, wbits, CONNECTED)
      & ~((wr_dm | wr_dh) ? wbits : 8'h00);
    next_cfg.pad.drive_mid_select = upd(cfg.pad.drive_mid_select, wr_dm, wbits, CONNECTED)
      & ~((wr_dl | wr_dh) ? wbits : 8'h00);
    next_cfg.pad.drive_high_select = upd(cfg.pad.drive_high_select, wr_dh, wbits, CONNECTED)
      & ~((wr_dl | wr_dm) ? wbits : 8'h00);
    next_cfg.pad.open_drain_select = upd(cfg.pad.open_drain_select,
      cfg_we && sel == gpio_pkg::SEL_OPEN_DRAIN, wbits, CONNECTED);
    next_cfg.pad.pull_up_select = upd(cfg.pad.pull_up_select,
      cfg_we && sel == gpio_pkg::SEL_PULL_UP, wbits, CONNECTED);
    next_cfg.pad.pull_down_select = upd(cfg.pad.pull_down_select,
      cfg_we && sel == gpio_pkg::SEL_PULL_DOWN, wbits, CONNECTED);
    next_cfg.pad.slew_control_select = upd(cfg.pad.slew_control_select,
      cfg_we && sel == gpio_pkg::SEL_SLEW, wbits, CONNECTED);
    next_cfg.pad.digital_input_enable = upd(cfg.pad.digital_input_enable,
      cfg_we && sel == gpio_pkg::SEL_DIGITAL_EN, wbits, CONNECTED);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data register with address-bit masking
  logic [7:0] data_bits, in_val, rd_val;
  assign data_bits = DATA_REQ.addr_mask & CONNECTED;
  assign next_pin_data = DATA_REQ.we ?
    ((pin_data & ~data_bits) | (DATA_REQ.wdata & data_bits)) : pin_data;
  // Digital enable off keeps a floating pad out of the logic
  assign in_val = pin_sync & cfg.pad.digital_input_enable;
  assign rd_val = (pin_data & cfg.pin_direction) | (in_val & ~cfg.pin_direction);

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt detection
  logic [7:0] rise, fall, edge_hit, level_hit, edge_new, hold_bits, clr_idle;
  logic [7:0] lvl_sel, lvl_set;
  logic any_masked;
  assign rise = in_val & ~pin_prev;
  assign fall = ~in_val & pin_prev;
  assign edge_hit = (cfg.irq_both_edges & (rise | fall))
    | (~cfg.irq_both_edges & cfg.irq_event_polarity & rise)
    | (~cfg.irq_both_edges & ~cfg.irq_event_polarity & fall);
  assign level_hit = (cfg.irq_event_polarity & in_val)
    | (~cfg.irq_event_polarity & ~in_val);
  // Set wins over clear; a level condition simply follows the pin
  assign next_irq_raw = CONNECTED & ((cfg.irq_sense_select & level_hit)
    | (~cfg.irq_sense_select & ((irq_raw_status & ~wr_clear) | edge_hit)));
  assign any_masked = |(irq_raw_status & cfg.irq_mask);
  assign edge_new = edge_hit & ~cfg.irq_sense_select & CONNECTED;
  assign hold_bits = irq_raw_status & ~cfg.irq_sense_select & ~wr_clear;
  assign clr_idle = wr_clear & ~cfg.irq_sense_select & ~edge_hit;
  assign lvl_sel = cfg.irq_sense_select & CONNECTED;
  assign lvl_set = lvl_sel & level_hit;

  // State registers; both resets bring back the defaults
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cfg <= CFG_DEFAULT;
      pin_data <= 8'h00;
      irq_raw_status <= 8'h00;
      pin_prev <= 8'h00;
    end else if (ext_rst) begin
      cfg <= CFG_DEFAULT;
      pin_data <= 8'h00;
      irq_raw_status <= 8'h00;
      pin_prev <= 8'h00;
    end else begin
      cfg <= next_cfg;
      pin_data <= next_pin_data;
      irq_raw_status <= next_irq_raw;
      pin_prev <= in_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration read mux
  logic [7:0] cfg_rd_val;
  logic [6:0] ident_pos;
  assign ident_pos = 7'((sel - gpio_pkg::SEL_IDENT_BASE) * 8); // Bit offset of the code
  always_comb begin
    case (sel)
      gpio_pkg::SEL_DIRECTION: cfg_rd_val = cfg.pin_direction;
      gpio_pkg::SEL_SENSE: cfg_rd_val = cfg.irq_sense_select;
      gpio_pkg::SEL_BOTH_EDGES: cfg_rd_val = cfg.irq_both_edges;
      gpio_pkg::SEL_EVENT: cfg_rd_val = cfg.irq_event_polarity;
      gpio_pkg::SEL_MASK: cfg_rd_val = cfg.irq_mask;
      gpio_pkg::SEL_RAW_STATUS: cfg_rd_val = irq_raw_status;
      gpio_pkg::SEL_MASKED_STATUS: cfg_rd_val = irq_raw_status & cfg.irq_mask;
      gpio_pkg::SEL_ALT_FUNCTION: cfg_rd_val = cfg.alt_function_select;
      gpio_pkg::SEL_DRIVE_LOW: cfg_rd_val = cfg.pad.drive_low_select;
      gpio_pkg::SEL_DRIVE_MID: cfg_rd_val = cfg.pad.drive_mid_select;
      gpio_pkg::SEL_DRIVE_HIGH: cfg_rd_val = cfg.pad.drive_high_select;
      gpio_pkg::SEL_OPEN_DRAIN: cfg_rd_val = cfg.pad.open_drain_select;
      gpio_pkg::SEL_PULL_UP: cfg_rd_val = cfg.pad.pull_up_select;
      gpio_pkg::SEL_PULL_DOWN: cfg_rd_val = cfg.pad.pull_down_select;
      gpio_pkg::SEL_SLEW: cfg_rd_val = cfg.pad.slew_control_select;
      gpio_pkg::SEL_DIGITAL_EN: cfg_rd_val = cfg.pad.digital_input_enable;
      gpio_pkg::SEL_LOCK: cfg_rd_val = cfg.unlocked ? gpio_pkg::LOCK_STATUS_OPEN
                                                  : gpio_pkg::LOCK_STATUS_LOCKED;
      gpio_pkg::SEL_COMMIT: cfg_rd_val = cfg.commit_enable;
      default: begin
        if (sel >= gpio_pkg::SEL_IDENT_BASE && sel <= gpio_pkg::SEL_IDENT_LAST) begin
          cfg_rd_val = IDENT_VALUES[ident_pos +: 8];
        end else begin
          cfg_rd_val = 8'h00;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pad and peripheral drive; open drain only ever pulls low
  logic [7:0] own_out, own_oe, next_pad_out, next_pad_oe;
  assign own_out = (cfg.alt_function_select & ALT_OUT)
    | (~cfg.alt_function_select & pin_data);
  assign own_oe = (cfg.alt_function_select & ALT_OE)
    | (~cfg.alt_function_select & cfg.pin_direction);
  assign next_pad_out = own_out & ~cfg.pad.open_drain_select;
  assign next_pad_oe = CONNECTED & ((own_oe & ~cfg.pad.open_drain_select)
    | (own_oe & ~own_out & cfg.pad.open_drain_select));

  // Output registers; reads hold their value until the next read
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CFG_RDATA <= 8'h00;
      DATA_RDATA <= 8'h00;
      PAD_OUT <= 8'h00;
      PAD_OE <= 8'h00;
      PAD_CFG <= CFG_DEFAULT.pad;
      ALT_IN <= 8'h00;
      ALT_SELECT <= DEBUG_PINS;
      IRQ <= 1'b0;
    end else begin
      if (CFG_REQ.re) begin
        CFG_RDATA <= cfg_rd_val;
      end
      if (DATA_REQ.re) begin
        DATA_RDATA <= rd_val & data_bits;
      end
      PAD_OUT <= next_pad_out;
      PAD_OE <= next_pad_oe;
      PAD_CFG <= cfg.pad;
      ALT_IN <= in_val;
      ALT_SELECT <= cfg.alt_function_select;
      IRQ <= any_masked;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  logic [7:0] dir_gpio, gpio_bits, data_keep;
  assign gpio_bits = ~cfg.alt_function_select & ~cfg.pad.open_drain_select & CONNECTED;
  assign dir_gpio = cfg.pin_direction & gpio_bits;
  assign data_keep = pin_data & ~data_bits;

  sequence edge_seen_s;
    !ext_rst && edge_new != 8'h00;
  endsequence
  sequence clear_seen_s;
    !ext_rst && clr_idle != 8'h00;
  endsequence

  data_write_mask_a: assert property (
    DATA_REQ.we && !ext_rst |=> (pin_data & ~$past(data_bits)) == $past(data_keep))
    else $error("masked data write touched an unselected bit");
  data_read_mask_a: assert property (
    DATA_REQ.re |=> (DATA_RDATA & ~$past(data_bits)) == 8'h00)
    else $error("masked data read leaked an unselected bit");
  alt_protect_a: assert property (
    cfg_we && sel == gpio_pkg::SEL_ALT_FUNCTION && !cfg.unlocked && !ext_rst
    |=> (cfg.alt_function_select & DEBUG_PINS) == ($past(cfg.alt_function_select) & DEBUG_PINS))
    else $error("protected alternate function bit changed while locked");
  edge_latch_a: assert property (
    edge_seen_s |=> (irq_raw_status & $past(edge_new)) == $past(edge_new))
    else $error("detected edge not latched in raw status");
  edge_hold_a: assert property (
    !ext_rst |=> (irq_raw_status & $past(hold_bits)) == $past(hold_bits))
    else $error("latched edge interrupt dropped without a clear");
  irq_clear_a: assert property (
    clear_seen_s |=> (irq_raw_status & $past(clr_idle)) == 8'h00)
    else $error("write of one to clear did not clear the interrupt");
  level_raw_a: assert property (
    !ext_rst |=> (irq_raw_status & $past(lvl_sel)) == $past(lvl_set))
    else $error("raw status does not follow the level condition");
  irq_output_a: assert property (
    any_masked ##1 any_masked |-> IRQ)
    else $error("unmasked condition did not reach the interrupt output");
  dir_drive_a: assert property (
    !ext_rst |=> (PAD_OE & $past(gpio_bits)) == $past(dir_gpio))
    else $error("pad enable does not follow direction in software mode");
  reset_default_a: assert property (
    ext_rst |=> cfg == CFG_DEFAULT ##1 PAD_CFG == CFG_DEFAULT.pad)
    else $error("external reset did not restore the default configuration");
endmodule // gpio_port_block

`default_nettype wire

//--- bench/pad_partner.sv
`timescale 1ns/1ns
`default_nettype none

module pad_partner (
  // Clock
  input wire logic clk,
  // Port side of the pads
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire gpio_pkg::pad_cfg_t pad_cfg,
  // Outside world
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pad_in
);
  logic [7:0] float_pat = 8'h55;

  ////////////////////////////////////////////////////////////////////////////
  // A floating pin without pulls must not read as a stable last value
  // Plain process, since the pattern also carries a declaration initial value
  always @(posedge clk) begin
    float_pat <= ~float_pat;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wire level: port driver first, then outside driver held steady, then pulls
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (ext_en[i]) begin
        pad_in[i] = ext_val[i];
      end else if (pad_cfg.pull_up_select[i]) begin
        pad_in[i] = 1'b1;
      end else if (pad_cfg.pull_down_select[i]) begin
        pad_in[i] = 1'b0;
      end else begin
        pad_in[i] = float_pat[i];
      end
    end
  end
endmodule // pad_partner

`default_nettype wire

//--- bench/test_gpio_port_block.sv
`timescale 1ns/1ns
`default_nettype none

module test_gpio_port_block;
  // Identification values are arbitrary
  localparam logic [95:0] IDENT = 96'hC3B2A190_8F7E6D5C_4B3A2918;
  logic SYS_CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic EXT_RESET_N = 1'b1;
  gpio_pkg::cfg_req_t CFG_REQ = '0;
  gpio_pkg::data_req_t DATA_REQ = '0;
  logic [7:0] CFG_RDATA, DATA_RDATA, PAD_IN, PAD_OUT, PAD_OE, ALT_IN, ALT_SELECT;
  logic [7:0] ALT_OUT = 8'h00;
  logic [7:0] ALT_OE = 8'h00;
  logic [7:0] ext_en = 8'h00;
  logic [7:0] ext_val = 8'h00;
  gpio_pkg::pad_cfg_t PAD_CFG;
  logic IRQ;
  int failures = 0;
  int checked = 0;
  logic [7:0] rd;

  gpio_port_block #(.IDENT_VALUES(IDENT)) dut_u (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
    .EXT_RESET_N(EXT_RESET_N), .CFG_REQ(CFG_REQ), .CFG_RDATA(CFG_RDATA),
    .DATA_REQ(DATA_REQ), .DATA_RDATA(DATA_RDATA), .PAD_IN(PAD_IN), .PAD_OUT(PAD_OUT),
    .PAD_OE(PAD_OE), .PAD_CFG(PAD_CFG), .ALT_OUT(ALT_OUT), .ALT_OE(ALT_OE),
    .ALT_IN(ALT_IN), .ALT_SELECT(ALT_SELECT), .IRQ(IRQ));
  pad_partner pads_u (.clk(SYS_CLK), .pad_out(PAD_OUT), .pad_oe(PAD_OE), .pad_cfg(PAD_CFG),
    .ext_en(ext_en), .ext_val(ext_val), .pad_in(PAD_IN));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, comparison and closing
  initial begin
    forever #50 SYS_CLK = ~SYS_CLK;
  end
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic ticks(int n);
    repeat (n) @(posedge SYS_CLK);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Access tasks: request on one edge, drop it on the next, read once settled
  task automatic cfg_wr(logic [5:0] sel, logic [7:0] d);
    @(posedge SYS_CLK) CFG_REQ <= '{1'b1, 1'b0, gpio_pkg::cfg_sel_t'(sel), d};
    @(posedge SYS_CLK) CFG_REQ <= '0;
  endtask
  task automatic cfg_rd(logic [5:0] sel, output logic [7:0] v);
    @(posedge SYS_CLK) CFG_REQ <= '{1'b0, 1'b1, gpio_pkg::cfg_sel_t'(sel), 8'h00};
    @(posedge SYS_CLK) CFG_REQ <= '0;
    #1 v = CFG_RDATA;
  endtask
  task automatic dat_wr(logic [7:0] m, logic [7:0] d);
    @(posedge SYS_CLK) DATA_REQ <= '{1'b1, 1'b0, m, d};
    @(posedge SYS_CLK) DATA_REQ <= '0;
  endtask
  task automatic dat_rd(logic [7:0] m, output logic [7:0] v);
    @(posedge SYS_CLK) DATA_REQ <= '{1'b0, 1'b1, m, 8'h00};
    @(posedge SYS_CLK) DATA_REQ <= '0;
    #1 v = DATA_RDATA;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic defaults_check(string tag);
    #1 check({tag, " alt"}, ALT_SELECT, 8'h0F);
    check({tag, " pull_up"}, PAD_CFG.pull_up_select, 8'h0F);
    check({tag, " den"}, PAD_CFG.digital_input_enable, 8'h0F);
    check({tag, " pull_down"}, PAD_CFG.pull_down_select, 8'h00);
    check({tag, " oe"}, PAD_OE, 8'h00);
    cfg_rd(gpio_pkg::SEL_DIRECTION, rd);
    check({tag, " dir"}, rd, 8'h00);
  endtask
  task automatic commit_protect();
    cfg_wr(gpio_pkg::SEL_ALT_FUNCTION, 8'h00);
    cfg_rd(gpio_pkg::SEL_ALT_FUNCTION, rd);
    check("locked alt", rd, 8'h0F);
    cfg_wr(gpio_pkg::SEL_LOCK, 8'hA5);
    cfg_rd(gpio_pkg::SEL_LOCK, rd);
    check("lock open", rd, gpio_pkg::LOCK_STATUS_OPEN);
    cfg_wr(gpio_pkg::SEL_COMMIT, 8'h0F);
    cfg_wr(gpio_pkg::SEL_ALT_FUNCTION, 8'h00);
    cfg_rd(gpio_pkg::SEL_ALT_FUNCTION, rd);
    check("open alt", rd, 8'h00);
  endtask
  task automatic data_out();
    cfg_wr(gpio_pkg::SEL_DIRECTION, 8'hFF);
    dat_wr(8'hFF, 8'h00);
    dat_wr(8'h26, 8'hEB);
    ticks(2);
    #1 check("pad_out", PAD_OUT, 8'h22);
    check("pad_oe", PAD_OE, 8'hFF);
    dat_rd(8'h31, rd);
    check("masked read", rd, 8'h20);
  endtask
  task automatic data_in();
    cfg_wr(gpio_pkg::SEL_DIRECTION, 8'h00);
    cfg_wr(gpio_pkg::SEL_DIGITAL_EN, 8'hFF);
    @(posedge SYS_CLK) ext_en <= 8'hFF;
    ext_val <= 8'h5A;
    ticks(4);
    dat_rd(8'hFF, rd);
    check("input data", rd, 8'h5A);
    dat_rd(8'h0F, rd);
    check("input masked", rd, 8'h0A);
    check("alt_in", ALT_IN, 8'h5A);
  endtask
  task automatic alt_mode();
    @(posedge SYS_CLK) ALT_OUT <= 8'h10;
    ALT_OE <= 8'h10;
    cfg_wr(gpio_pkg::SEL_ALT_FUNCTION, 8'h10);
    ticks(2);
    #1 check("alt select", ALT_SELECT, 8'h10);
    check("alt oe", PAD_OE, 8'h10);
    check("alt out", PAD_OUT & 8'h10, 8'h10);
  endtask
  task automatic irq_modes();
    logic [5:0] tbl [6] = '{6'b001011, 6'b000101, 6'b010101, 6'b101011, 6'b100101, 6'b001100};
    cfg_wr(gpio_pkg::SEL_MASK, 8'h00);
    foreach (tbl[i]) begin
      cfg_wr(gpio_pkg::SEL_SENSE, {2'b00, tbl[i][5], 5'b00000});
      cfg_wr(gpio_pkg::SEL_BOTH_EDGES, {2'b00, tbl[i][4], 5'b00000});
      cfg_wr(gpio_pkg::SEL_EVENT, {2'b00, tbl[i][3], 5'b00000});
      @(posedge SYS_CLK) ext_val[5] <= tbl[i][2];
      ticks(5);
      cfg_wr(gpio_pkg::SEL_CLEAR, 8'hFF);
      @(posedge SYS_CLK) ext_val[5] <= tbl[i][1];
      ticks(5);
      cfg_rd(gpio_pkg::SEL_RAW_STATUS, rd);
      check("raw mode", rd, {2'b00, tbl[i][0], 5'b00000});
    end
  endtask
  task automatic irq_latch();
    cfg_wr(gpio_pkg::SEL_SENSE, 8'h00);
    cfg_wr(gpio_pkg::SEL_EVENT, 8'h20);
    cfg_wr(gpio_pkg::SEL_CLEAR, 8'hFF);
    @(posedge SYS_CLK) ext_val[5] <= 1'b1;
    ticks(4);
    @(posedge SYS_CLK) ext_val[5] <= 1'b0;
    ticks(5);
    cfg_rd(gpio_pkg::SEL_RAW_STATUS, rd);
    check("edge held", rd, 8'h20);
    cfg_rd(gpio_pkg::SEL_MASKED_STATUS, rd);
    check("masked off", rd, 8'h00);
    check("irq masked", {7'h00, IRQ}, 8'h00);
    cfg_wr(gpio_pkg::SEL_MASK, 8'h20);
    cfg_rd(gpio_pkg::SEL_MASKED_STATUS, rd);
    check("masked on", rd, 8'h20);
    ticks(1);
    #1 check("irq on", {7'h00, IRQ}, 8'h01);
    cfg_wr(gpio_pkg::SEL_CLEAR, 8'h00);
    cfg_rd(gpio_pkg::SEL_RAW_STATUS, rd);
    check("clear zero", rd, 8'h20);
    cfg_wr(gpio_pkg::SEL_CLEAR, 8'h20);
    cfg_rd(gpio_pkg::SEL_RAW_STATUS, rd);
    check("clear one", rd, 8'h00);
    ticks(2);
    #1 check("irq off", {7'h00, IRQ}, 8'h00);
  endtask
  task automatic pad_ident();
    logic [5:0] sels [3] = '{gpio_pkg::SEL_PULL_DOWN, gpio_pkg::SEL_OPEN_DRAIN, gpio_pkg::SEL_SLEW};
    foreach (sels[i]) begin
      cfg_wr(sels[i], 8'h3C);
      cfg_rd(sels[i], rd);
      check("pad reg", rd, 8'h3C);
    end
    cfg_wr(gpio_pkg::SEL_DRIVE_HIGH, 8'h01);
    cfg_rd(gpio_pkg::SEL_DRIVE_LOW, rd);
    check("drive low", rd, 8'hFE);
    check("drive high pad", PAD_CFG.drive_high_select, 8'h01);
    for (int k = 0; k < 12; k++) begin
      cfg_wr(6'h20 + 6'(k), 8'h00);
      cfg_rd(6'h20 + 6'(k), rd);
      check("ident", rd, IDENT[8*k+:8]);
    end
    cfg_rd(6'h3F, rd);
    check("unmapped", rd, 8'h00);
  endtask
  task automatic ext_reset();
    @(posedge SYS_CLK) EXT_RESET_N <= 1'b0;
    ticks(4);
    @(posedge SYS_CLK) EXT_RESET_N <= 1'b1;
    ticks(5);
    defaults_check("ext");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    ticks(6);
    @(posedge SYS_CLK) RESET_N <= 1'b1;
    ticks(4);
    defaults_check("por");
    commit_protect();
    data_out();
    data_in();
    alt_mode();
    irq_modes();
    irq_latch();
    pad_ident();
    ext_reset();
    stop_test();
  end
  initial begin
    #(5000 * 100);
    failures++;
    stop_test();
  end
endmodule // test_gpio_port_block

`default_nettype wire
